// ==== rtl/flash_link_pkg.sv ====
// Constants, opcodes and timing for the serial flash command link
package flash_link_pkg;

  // Core clock rate
  localparam int REF_MHZ = 200;

  // Command frame layout: opcode then 24 address bits
  localparam int OPC_W = 8;
  localparam int PAGE_W = 11;
  localparam int BYTE_W = 9;
  localparam int FRAME_W = 32;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 24;
  localparam int RSV_HI = 23;
  localparam int RSV_LO = 20;
  localparam int PAGE_HI = 19;
  localparam int PAGE_LO = 9;
  localparam int BYTE_HI = 8;
  localparam int BYTE_LO = 0;

  // Bit counter marks in the link domain
  localparam logic [5:0] BIT_LAST = 6'h1f;
  localparam logic [5:0] BIT_DONE = 6'h20;
  localparam logic [5:0] BIT_ONE = 6'h01;
  localparam logic [5:0] BIT_ZERO = 6'h00;

  // Opcodes that start an internal operation
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_XFR_BUF1 = 8'h53;
  localparam logic [7:0] OP_XFR_BUF2 = 8'h55;
  localparam logic [7:0] OP_REWRITE_BUF1 = 8'h58;
  localparam logic [7:0] OP_REWRITE_BUF2 = 8'h59;
  localparam logic [7:0] OP_CMP_BUF1 = 8'h60;
  localparam logic [7:0] OP_CMP_BUF2 = 8'h61;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_PROG_THRU_BUF1 = 8'h82;
  localparam logic [7:0] OP_PROG_ERASE_BUF1 = 8'h83;
  localparam logic [7:0] OP_PROG_THRU_BUF2 = 8'h85;
  localparam logic [7:0] OP_PROG_ERASE_BUF2 = 8'h86;
  localparam logic [7:0] OP_PROG_BUF1 = 8'h88;
  localparam logic [7:0] OP_PROG_BUF2 = 8'h89;

  // Worst-case times as printed
  localparam int T_XFR_US = 150;
  localparam int T_EP_MS = 20;
  localparam int T_P_MS = 14;
  localparam int T_PE_MS = 8;
  localparam int T_BE_MS = 12;
  localparam int T_CSB_NS = 200;

  // Longest times rounded down to whole core cycles
  localparam int XFR_CYC_DEF = T_XFR_US * REF_MHZ;
  localparam int EP_CYC_DEF = T_EP_MS * REF_MHZ * 1000;
  localparam int P_CYC_DEF = T_P_MS * REF_MHZ * 1000;
  localparam int PE_CYC_DEF = T_PE_MS * REF_MHZ * 1000;
  localparam int BE_CYC_DEF = T_BE_MS * REF_MHZ * 1000;
  localparam int CSB_CYC = T_CSB_NS * REF_MHZ / 1000;

  // Busy counter width, holds the longest count
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 22'h00_0001;

  // Operation sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } op_state_t;

endpackage : flash_link_pkg

// ==== rtl/sync_2ff.sv ====
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Level in and out
  input wire logic d,
  output logic q
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // Next values of the two stages
  always_comb
  begin
    meta_d = d;
    sync_d = meta_q;
  end

  // Only the second stage reads the first
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;

endmodule : sync_2ff
`default_nettype wire

// ==== rtl/flash_cmd_link.sv ====
// Serial flash command link: frame capture, launch and ready/busy timing
// Contract
// - Each serial input bit is captured on the rising serial clock edge.
// - Frames are valid whether the clock idles low or high at select fall.
// - Idle-low works as SPI mode 0, idle-high as SPI mode 3.
// - Reserved address bits are ignored; larger parts use them as page bits.
// - Page-to-buffer transfer or compare finishes within 150 us.
// - Erase+program 20 ms, program 14 ms, block erase 12 ms, page erase 8 ms.
// - Ready/busy goes low within 200 ns of select rising to launch.
// - Frame is opcode, 4 reserved, 11 page and 9 byte address bits.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_link #(
  parameter int unsigned XFR_CYC = flash_link_pkg::XFR_CYC_DEF,
  parameter int unsigned EP_CYC = flash_link_pkg::EP_CYC_DEF,
  parameter int unsigned P_CYC = flash_link_pkg::P_CYC_DEF,
  parameter int unsigned PE_CYC = flash_link_pkg::PE_CYC_DEF,
  parameter int unsigned BE_CYC = flash_link_pkg::BE_CYC_DEF
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial link from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic dev_reset_n,
  // Status back to the host
  output logic rdy_busy,
  // Internal operation request
  output logic op_start,
  output logic [flash_link_pkg::OPC_W-1:0] op_code,
  output logic [flash_link_pkg::PAGE_W-1:0] op_page,
  output logic [flash_link_pkg::BYTE_W-1:0] op_byte
);

  localparam int csb_lim = flash_link_pkg::CSB_CYC;

  // Busy length for an opcode, zero when it starts nothing
  function automatic logic [flash_link_pkg::CNT_W-1:0] op_cycles(
    input logic [flash_link_pkg::OPC_W-1:0] opc
  );
    logic [flash_link_pkg::CNT_W-1:0] n;
    n = flash_link_pkg::CNT_ZERO;
    case (opc)
      flash_link_pkg::OP_XFR_BUF1,
      flash_link_pkg::OP_XFR_BUF2,
      flash_link_pkg::OP_CMP_BUF1,
      flash_link_pkg::OP_CMP_BUF2: n = flash_link_pkg::CNT_W'(XFR_CYC);
      flash_link_pkg::OP_REWRITE_BUF1,
      flash_link_pkg::OP_REWRITE_BUF2,
      flash_link_pkg::OP_PROG_THRU_BUF1,
      flash_link_pkg::OP_PROG_THRU_BUF2,
      flash_link_pkg::OP_PROG_ERASE_BUF1,
      flash_link_pkg::OP_PROG_ERASE_BUF2: n = flash_link_pkg::CNT_W'(EP_CYC);
      flash_link_pkg::OP_PROG_BUF1,
      flash_link_pkg::OP_PROG_BUF2: n = flash_link_pkg::CNT_W'(P_CYC);
      flash_link_pkg::OP_PAGE_ERASE: n = flash_link_pkg::CNT_W'(PE_CYC);
      flash_link_pkg::OP_BLOCK_ERASE: n = flash_link_pkg::CNT_W'(BE_CYC);
      default: n = flash_link_pkg::CNT_ZERO;
    endcase
    return n;
  endfunction : op_cycles

  // Link domain state, clocked by the serial clock
  logic link_clr;
  logic [5:0] bit_cnt_q;
  logic [5:0] bit_cnt_d;
  logic [30:0] shift_q;
  logic [30:0] shift_d;
  logic [flash_link_pkg::FRAME_W-1:0] frame_q;
  logic [flash_link_pkg::FRAME_W-1:0] frame_d;
  logic tog_q;
  logic tog_d;

  // Counter restarts whenever select is high
  assign link_clr = rst | cs_n;

  // Shift in opcode and address, hand the word over on the last bit
  always_comb
  begin
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    frame_d = frame_q;
    tog_d = tog_q;
    if (bit_cnt_q != flash_link_pkg::BIT_DONE)
    begin
      shift_d = {shift_q[29:0], si};
      bit_cnt_d = bit_cnt_q + flash_link_pkg::BIT_ONE;
      if (bit_cnt_q == flash_link_pkg::BIT_LAST)
      begin
        frame_d = {shift_q, si};
        tog_d = ~tog_q;
      end
    end
  end

  // Rising edges only; the idle level never counts as an edge
  always_ff @(posedge sck or posedge link_clr)
  begin
    if (link_clr)
    begin
      bit_cnt_q <= flash_link_pkg::BIT_ZERO;
      shift_q <= '0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
    end
  end

  // Frame word and its handover toggle survive select going high
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      frame_q <= '0;
      tog_q <= 1'b0;
    end
    else
    begin
      frame_q <= frame_d;
      tog_q <= tog_d;
    end
  end
  // Crossings into the core domain
  logic cs_s;
  logic tog_s;
  logic rstp_s;
  sync_2ff #(.RST_VAL(1'b1)) u_sync_cs (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(cs_n),
    .q(cs_s)
  );
  sync_2ff #(.RST_VAL(1'b0)) u_sync_tog (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(tog_q),
    .q(tog_s)
  );
  sync_2ff #(.RST_VAL(1'b0)) u_sync_rstp (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(dev_reset_n),
    .q(rstp_s)
  );
  // Core domain state
  flash_link_pkg::op_state_t st_q;
  flash_link_pkg::op_state_t st_d;
  logic [flash_link_pkg::CNT_W-1:0] left_q;
  logic [flash_link_pkg::CNT_W-1:0] left_d;
  logic cs_prev_q;
  logic cs_prev_d;
  logic tog_seen_q;
  logic tog_seen_d;
  logic rdy_q;
  logic rdy_d;
  logic start_q;
  logic start_d;
  logic [flash_link_pkg::OPC_W-1:0] code_q;
  logic [flash_link_pkg::OPC_W-1:0] code_d;
  logic [flash_link_pkg::PAGE_W-1:0] page_q;
  logic [flash_link_pkg::PAGE_W-1:0] page_d;
  logic [flash_link_pkg::BYTE_W-1:0] byte_q;
  logic [flash_link_pkg::BYTE_W-1:0] byte_d;
  logic cs_rise;
  logic new_frame;
  logic [flash_link_pkg::CNT_W-1:0] dur;
  // Checking aids: busy run length and the limit it was given
  logic [flash_link_pkg::CNT_W-1:0] run_q;
  logic [flash_link_pkg::CNT_W-1:0] run_d;
  logic [flash_link_pkg::CNT_W-1:0] lim_q;
  logic [flash_link_pkg::CNT_W-1:0] lim_d;

  // Select rise with a fresh frame launches; busy counts down to ready
  always_comb
  begin
    cs_rise = cs_s & ~cs_prev_q;
    new_frame = tog_s ^ tog_seen_q;
    dur = op_cycles(frame_q[flash_link_pkg::OPC_HI:flash_link_pkg::OPC_LO]);
    st_d = st_q;
    left_d = left_q;
    rdy_d = rdy_q;
    start_d = 1'b0;
    code_d = code_q;
    page_d = page_q;
    byte_d = byte_q;
    cs_prev_d = cs_s;
    tog_seen_d = cs_rise ? tog_s : tog_seen_q;
    run_d = (st_q == flash_link_pkg::ST_BUSY) ? run_q + flash_link_pkg::CNT_ONE
                                              : flash_link_pkg::CNT_ZERO;
    case (st_q)
      flash_link_pkg::ST_IDLE:
      begin
        if (cs_rise && new_frame)
        begin
          code_d = frame_q[flash_link_pkg::OPC_HI:flash_link_pkg::OPC_LO];
          page_d = frame_q[flash_link_pkg::PAGE_HI:flash_link_pkg::PAGE_LO];
          byte_d = frame_q[flash_link_pkg::BYTE_HI:flash_link_pkg::BYTE_LO];
          if (dur != flash_link_pkg::CNT_ZERO)
          begin
            st_d = flash_link_pkg::ST_BUSY;
            left_d = dur;
            rdy_d = 1'b0;
            start_d = 1'b1;
          end
        end
      end
      flash_link_pkg::ST_BUSY:
      begin
        if (left_q <= flash_link_pkg::CNT_ONE)
        begin
          st_d = flash_link_pkg::ST_IDLE;
          left_d = flash_link_pkg::CNT_ZERO;
          rdy_d = 1'b1;
        end
        else
        begin
          left_d = left_q - flash_link_pkg::CNT_ONE;
        end
      end
      default:
      begin
        st_d = flash_link_pkg::ST_IDLE;
        left_d = flash_link_pkg::CNT_ZERO;
        rdy_d = 1'b1;
      end
    endcase
    // Reset pin aborts any operation and shows ready
    if (!rstp_s)
    begin
      st_d = flash_link_pkg::ST_IDLE;
      left_d = flash_link_pkg::CNT_ZERO;
      rdy_d = 1'b1;
      start_d = 1'b0;
    end
    lim_d = start_d ? dur : lim_q;
  end

  // Core domain registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= flash_link_pkg::ST_IDLE;
      left_q <= flash_link_pkg::CNT_ZERO;
      cs_prev_q <= 1'b1;
      tog_seen_q <= 1'b0;
      rdy_q <= 1'b1;
      start_q <= 1'b0;
      code_q <= '0;
      page_q <= '0;
      byte_q <= '0;
      run_q <= flash_link_pkg::CNT_ZERO;
      lim_q <= flash_link_pkg::CNT_ZERO;
    end
    else
    begin
      st_q <= st_d;
      left_q <= left_d;
      cs_prev_q <= cs_prev_d;
      tog_seen_q <= tog_seen_d;
      rdy_q <= rdy_d;
      start_q <= start_d;
      code_q <= code_d;
      page_q <= page_d;
      byte_q <= byte_d;
      run_q <= run_d;
      lim_q <= lim_d;
    end
  end

  // Outputs straight from flip-flops
  assign rdy_busy = rdy_q;
  assign op_start = start_q;
  assign op_code = code_q;
  assign op_page = page_q;
  assign op_byte = byte_q;

  // Link domain checks
  a_bit_capture: assert property (
    @(posedge sck) disable iff (link_clr)
    (bit_cnt_q < flash_link_pkg::BIT_LAST) |=> (shift_q[0] == $past(si)))
    else $error("serial bit not captured on rising edge");
  a_frame_count: assert property (
    @(posedge sck) disable iff (link_clr)
    (bit_cnt_q == flash_link_pkg::BIT_LAST) |=> (tog_q != $past(tog_q)))
    else $error("frame not completed on 32nd rising edge");
  a_frame_quiet: assert property (
    @(posedge sck) disable iff (link_clr)
    (bit_cnt_q != flash_link_pkg::BIT_LAST) |=> $stable(tog_q) && $stable(frame_q))
    else $error("frame handover outside the last bit");
  a_frame_latch: assert property (
    @(posedge sck) disable iff (link_clr)
    (bit_cnt_q == flash_link_pkg::BIT_LAST) |=> (frame_q == $past({shift_q, si})))
    else $error("frame word not latched in shift order");
  // Core domain checks
  a_reserved_ignored: assert property (
    @(posedge ref_clk) disable iff (rst)
    start_q |-> (page_q == $past(frame_q[flash_link_pkg::PAGE_HI:flash_link_pkg::PAGE_LO]))
      && (lim_q == op_cycles(code_q)))
    else $error("page field or length depends on reserved bits");
  a_busy_quick: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st_q == flash_link_pkg::ST_IDLE && cs_rise && new_frame && rstp_s
      && dur != flash_link_pkg::CNT_ZERO) |-> ##[1:csb_lim] !rdy_busy)
    else $error("busy not shown in time after select rise");
  a_xfr_bound: assert property (
    @(posedge ref_clk) disable iff (rst)
    (start_q && (code_q == flash_link_pkg::OP_XFR_BUF1 || code_q == flash_link_pkg::OP_XFR_BUF2
      || code_q == flash_link_pkg::OP_CMP_BUF1 || code_q == flash_link_pkg::OP_CMP_BUF2))
      |-> (lim_q == flash_link_pkg::CNT_W'(XFR_CYC)))
    else $error("transfer busy length wrong");
  a_erase_bound: assert property (
    @(posedge ref_clk) disable iff (rst)
    (start_q && code_q == flash_link_pkg::OP_BLOCK_ERASE)
      |-> (lim_q == flash_link_pkg::CNT_W'(BE_CYC)) && !rdy_busy)
    else $error("block erase busy length wrong");
  a_busy_limit: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st_q == flash_link_pkg::ST_BUSY) |-> (run_q < lim_q) && !rdy_busy)
    else $error("operation overran its worst-case time");
  a_ready_return: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st_q == flash_link_pkg::ST_BUSY && left_q == flash_link_pkg::CNT_ONE)
      |=> rdy_busy && (st_q == flash_link_pkg::ST_IDLE))
    else $error("ready not restored at end of operation");
endmodule : flash_cmd_link
`default_nettype wire

// ==== verif/spi_host_model.sv ====
// Behavioural SPI host that drives select, clock and data into the flash link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Serial link to the device
  output logic sck,
  output logic cs_n,
  output logic si
);
  // Link idles deselected with the clock parked
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // One frame, MSB first; clock parked at cpol outside the bits
  task automatic send_frame(input logic [31:0] w, input logic cpol, input int nbits);
    int i;
    // Select stays high its minimum time before the clock moves
    #250;
    sck = cpol;
    #250;
    cs_n = 1'b0;
    #250;
    // Bits past the 32nd carry filler; fixed test period, no array reads issued
    for (i = 0; i < nbits; i++)
    begin
      sck = 1'b0;
      si = (i < 32) ? w[31 - i] : ~si;
      #7.5;
      sck = 1'b1;
      #7.5;
    end
    sck = cpol;
    #250;
    cs_n = 1'b1;
    // Released data line shows a changed level, not the last bit
    si = ~si;
  endtask : send_frame
endmodule : spi_host_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the flash command link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic [7:0] code;
    logic [10:0] page;
    logic [8:0] byt;
    logic launch;
    int n;
  } note_t;
  localparam int XC = 200;
  localparam int EC = 600;
  localparam int PC = 500;
  localparam int PEC = 300;
  localparam int BC = 400;
  localparam logic [7:0] OPS [14] = '{8'h50, 8'h53, 8'h55, 8'h58, 8'h59, 8'h60, 8'h61,
    8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h88, 8'h89};
  localparam logic [7:0] NOPS [5] = '{8'hd2, 8'he8, 8'h52, 8'h54, 8'h68};
  logic ref_clk;
  logic rst;
  logic dev_reset_n;
  wire logic sck;
  wire logic cs_n;
  wire logic si;
  logic rdy_busy;
  logic op_start;
  logic [7:0] op_code;
  logic [10:0] op_page;
  logic [8:0] op_byte;
  logic cpol = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  note_t notes[$];

  // Host on the serial side
  spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si));

  // Device with shortened busy counts
  flash_cmd_link #(.XFR_CYC(XC), .EP_CYC(EC), .P_CYC(PC), .PE_CYC(PEC), .BE_CYC(BC)) dut (
    .ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .dev_reset_n(dev_reset_n), .rdy_busy(rdy_busy), .op_start(op_start),
    .op_code(op_code), .op_page(op_page), .op_byte(op_byte));

  // Busy length per opcode
  function automatic int len(input logic [7:0] op);
    case (op)
      8'h53, 8'h55, 8'h60, 8'h61: return XC;
      8'h58, 8'h59, 8'h82, 8'h83, 8'h85, 8'h86: return EC;
      8'h88, 8'h89: return PC;
      8'h81: return PEC;
      8'h50: return BC;
      default: return 0;
    endcase
  endfunction : len

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Send one random-address frame, note its result, check launch latency
  task automatic frame(input logic [7:0] op, input logic launch, input int n,
    input int nbits, input logic push);
    logic [31:0] w;
    int i;
    // Frames expected to launch keep reserved bits zero; other frames randomise them
    w = {op, launch ? 4'h0 : 4'($urandom), 11'($urandom), 9'($urandom)};
    if (push)
      notes.push_back('{op, w[19:9], w[8:0], launch, n});
    cpol = ~cpol;
    host.send_frame(w, cpol, nbits);
    if (launch)
    begin
      for (i = 0; i < 60 && rdy_busy !== 1'b0; i++)
        @(negedge ref_clk);
      check("launch latency", 32'(i <= flash_link_pkg::CSB_CYC), 32'h0000_0001);
    end
  endtask : frame

  // Host waits for ready before the next array operation
  task automatic wait_ready;
    int i;
    for (i = 0; i < 2000 && rdy_busy !== 1'b1; i++)
      @(negedge ref_clk);
    check("rdy_busy", 32'(rdy_busy), 32'h0000_0001);
  endtask : wait_ready

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Watchdog
  initial
  begin
    #300us;
    n_mismatch++;
    test_done();
  end

  // Result watcher: takes the oldest note whenever a result appears
  initial
  begin : monitor
    note_t nt;
    int cnt;
    logic [27:0] last;
    last = '0;
    forever
    begin
      @(negedge ref_clk);
      if (op_start === 1'b1 || {op_code, op_page, op_byte} !== last)
      begin
        last = {op_code, op_page, op_byte};
        if (notes.size() == 0)
        begin
          check("unexpected result", 32'h0000_0001, 32'h0000_0000);
        end
        else
        begin
          nt = notes.pop_front();
          check("op_code", 32'(op_code), 32'(nt.code));
          check("op_page", 32'(op_page), 32'(nt.page));
          check("op_byte", 32'(op_byte), 32'(nt.byt));
          check("op_start", 32'(op_start), 32'(nt.launch));
          if (nt.launch)
          begin
            cnt = 0;
            while (rdy_busy === 1'b0 && cnt < 5000)
            begin
              cnt++;
              @(negedge ref_clk);
            end
            if (nt.n >= 0)
              check("busy cycles", 32'(cnt), 32'(nt.n));
          end
        end
      end
    end
  end

  // Main sequence
  initial
  begin : main
    rst = 1'b1;
    dev_reset_n = 1'b1;
    void'($urandom(97));
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    // Every launching opcode, modes 0 and 3 alternating
    foreach (OPS[k])
    begin
      frame(OPS[k], 1'b1, len(OPS[k]), 32, 1'b1);
      wait_ready();
    end
    $display("test launch done");
    // Non-launching opcodes back to back
    foreach (NOPS[k])
      frame(NOPS[k], 1'b0, 0, 40, 1'b1);
    repeat (20) @(negedge ref_clk);
    $display("test plain done");
    // Frame sent while busy is dropped
    frame(8'h83, 1'b1, EC, 32, 1'b1);
    frame(8'h81, 1'b0, 0, 32, 1'b0);
    wait_ready();
    $display("test busy done");
    // Short frame is dropped
    frame(8'h50, 1'b0, 0, 20, 1'b0);
    repeat (50) @(negedge ref_clk);
    check("short frame", 32'(rdy_busy), 32'h0000_0001);
    $display("test short done");
    // Reset pin aborts busy; frames only update the fields while it is low
    frame(8'h86, 1'b1, -1, 32, 1'b1);
    repeat (20) @(negedge ref_clk);
    dev_reset_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("abort ready", 32'(rdy_busy), 32'h0000_0001);
    frame(8'h50, 1'b0, 0, 32, 1'b1);
    repeat (50) @(negedge ref_clk);
    check("ignored in reset", 32'(rdy_busy), 32'h0000_0001);
    dev_reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    frame(8'h88, 1'b1, PC, 32, 1'b1);
    wait_ready();
    repeat (10) @(negedge ref_clk);
    $display("test reset pin done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
